/* design/dsk_defs.svh */
`ifndef DSK_DEFS_SVH
`define DSK_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define DSK_SETTLE_MS 10
`define DSK_CLK_KHZ 100000

// ****************************************
// Widths and pin vector layout
// ****************************************
`define DSK_BUS_W 5
`define DSK_HEAD_W 4
`define DSK_SYNC_W 15
`define DSK_ADDR_W 12

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DSK_OFF_CTRL 12'h000
`define DSK_OFF_STATUS 12'h004
`define DSK_OFF_POSN 12'h008
`define DSK_OFF_INT_STS 12'h00c
`define DSK_OFF_INT_MASK 12'h010

// ****************************************
// Field positions
// ****************************************
`define DSK_CTRL_HOME 0
`define DSK_CTRL_FCLR 1
`define DSK_CB_WRITE 0
`define DSK_CB_READ 1
`define DSK_CB_SEEK 2
`define DSK_CB_HCLR 3
`define DSK_CB_ERASE 4
`define DSK_IRQ_POS 0
`define DSK_IRQ_FAULT 1
`define DSK_IRQ_REFUSED 2
`define DSK_IRQ_W 3
`define DSK_POSN_TGT_LSB 8
`define DSK_POSN_DIFF_LSB 16
`define DSK_POSN_HEAD_LSB 24
`define DSK_POSN_CTL_LSB 28
`define DSK_INT_MASK_RST 3'h0

`endif

/* design/dsk_host_port.sv */
// How it works
// - Once the pack is at speed the carriage drives forward until heads load, then reverses.
// - The reverse motion stops at cylinder zero when the detent engages.
// - Positioned status rises a fixed 10 ms after any positioning motion ends in detent.
// - Read, write, seek and home recalibrate are accepted only after first seek is done.
// - The shared bus is read according to whichever of the five strobes is active.
// - Under cylinder, offset, readback and head strobes bus bits weigh 1, 2, 4 and up.
// - Under the control strobe bit 0 enables the write drivers.
// - Under the control strobe bit 1 enables the read data output line.
// - Under the control strobe bit 2 starts forward carriage movement.
// - Under the control strobe bit 3 clears the head register; bit 3 weighs 8 otherwise.
// - Under the control strobe bit 4 enables the erase driver.
// - Read and write selected together set the fault flag, which stays clear until recurrence.
// - Read, write or erase selected without positioned status sets the fault flag.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "dsk_defs.svh"
`default_nettype none
module dsk_host_port #(
   parameter int SETTLE_CYCLES = `DSK_SETTLE_MS * `DSK_CLK_KHZ
) (
   input wire logic CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [`DSK_ADDR_W-1:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic SEQUENCE_IN,
   input wire logic PACK_AT_SPEED_IN,
   input wire logic HEADS_LOADED_IN,
   input wire logic DETENT_ENGAGED_IN,
   input wire logic CYL_ZERO_IN,
   input wire logic [4:0] SELECT_IN,
   input wire logic [`DSK_BUS_W-1:0] BUS_DATA_IN,
   output logic [`DSK_BUS_W-1:0] BUS_DATA_OUT,
   output logic BUS_OE_N_OUT,
   output logic CARRIAGE_FWD_OUT,
   output logic CARRIAGE_REV_OUT,
   output logic POSITIONED_OUT,
   output logic WRITE_DRV_EN_OUT,
   output logic READ_DATA_EN_OUT,
   output logic ERASE_EN_OUT,
   output logic [`DSK_HEAD_W-1:0] HEAD_ADDR_OUT,
   output logic FAULT_OUT,
   output logic IRQ_OUT,
   output var dsk_pkg::dsk_state_t STATE_OUT
);
   import dsk_pkg::*;

   // ****************************************
   // Pin synchronisation
   // ****************************************
   logic [`DSK_SYNC_W-1:0] pins_s;
   logic seq_s, speed_s, loaded_s, detent_s, zero_s;
   logic [4:0] stb_s;
   logic [`DSK_BUS_W-1:0] bus_s;
   logic detent_q_ff;
   logic det_rise;
   dsk_sel_t sel;

   dsk_sync #(.W(`DSK_SYNC_W)) u_sync (
      .clk_in(CLK_IN),
      .arst_n_in(ARST_N_IN),
      .d_in({SEQUENCE_IN, PACK_AT_SPEED_IN, HEADS_LOADED_IN, DETENT_ENGAGED_IN,
             CYL_ZERO_IN, SELECT_IN, BUS_DATA_IN}),
      .q_out(pins_s)
   );

   // Strobe and bus share one sync stage so they stay aligned
   assign {seq_s, speed_s, loaded_s, detent_s, zero_s, stb_s, bus_s} = pins_s;
   assign sel = dsk_decode_sel(stb_s);
   assign det_rise = detent_s && !detent_q_ff;

   // Edge memory for detent; resets as engaged, yet the synchroniser resets low, so a resting pin still gives one edge two clocks after reset
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         detent_q_ff <= 1'b1;
      end else begin
         detent_q_ff <= detent_s;
      end
   end

   // ****************************************
   // Bus capture registers
   // ****************************************
   logic [`DSK_BUS_W-1:0] tgt_ff, diff_ff, ctl_ff, cur_ff;
   logic [`DSK_HEAD_W-1:0] head_ff;
   logic seek_req, home_req, positioned_ff;

   // Latch only under the matching strobe; idle bus is ignored
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         tgt_ff <= '0;
         diff_ff <= '0;
         ctl_ff <= '0;
      end else begin
         if (sel == DSK_SEL_CYL) tgt_ff <= bus_s;
         if (sel == DSK_SEL_DIFF) diff_ff <= bus_s;
         if (sel == DSK_SEL_CTL) ctl_ff <= bus_s;
      end
   end

   // Head register; control bit 3 clears it
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         head_ff <= '0;
      end else if (sel == DSK_SEL_CTL && bus_s[`DSK_CB_HCLR]) begin
         head_ff <= '0;
      end else if (sel == DSK_SEL_HEAD) begin
         head_ff <= bus_s[`DSK_HEAD_W-1:0];
      end
   end

   // Seek fires on the 0-to-1 of bit 2, so a held strobe seeks once
   assign seek_req = (sel == DSK_SEL_CTL) && bus_s[`DSK_CB_SEEK] && !ctl_ff[`DSK_CB_SEEK];

   // Readback drives the current cylinder; enable low while driving
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         BUS_DATA_OUT <= '0;
         BUS_OE_N_OUT <= 1'b1;
      end else begin
         BUS_DATA_OUT <= (sel == DSK_SEL_RDCYL) ? cur_ff : '0;
         BUS_OE_N_OUT <= (sel != DSK_SEL_RDCYL);
      end
   end

   // ****************************************
   // Positioning sequencer
   // ****************************************
   dsk_state_t state_ff, nxt_state;
   logic settle_done;

   dsk_settle_timer #(.LIMIT(SETTLE_CYCLES)) u_settle (
      .clk_in(CLK_IN),
      .arst_n_in(ARST_N_IN),
      .run_in(state_ff == DSK_SETTLE),
      .done_out(settle_done)
   );

   // Dropping the sequence signal powers the mechanism down from anywhere
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         DSK_IDLE: if (seq_s) nxt_state = DSK_SPIN;
         DSK_SPIN: if (speed_s) nxt_state = DSK_LOAD;
         DSK_LOAD: if (loaded_s) nxt_state = DSK_RETRACT;
         DSK_RETRACT: if (det_rise && zero_s) nxt_state = DSK_SETTLE;
         DSK_SEEK: if (det_rise) nxt_state = DSK_SETTLE;
         DSK_SETTLE: if (settle_done) nxt_state = DSK_READY;
         DSK_READY: begin
            if (home_req) nxt_state = DSK_RETRACT;
            else if (seek_req) nxt_state = DSK_SEEK;
         end
         default: nxt_state = DSK_IDLE;
      endcase
      if (!seq_s) nxt_state = DSK_IDLE;
   end

   // State, carriage drive and positioned status
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_ff <= DSK_IDLE;
         positioned_ff <= 1'b0;
         CARRIAGE_FWD_OUT <= 1'b0;
         CARRIAGE_REV_OUT <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         positioned_ff <= (nxt_state == DSK_READY);
         CARRIAGE_FWD_OUT <= (nxt_state == DSK_LOAD) || (nxt_state == DSK_SEEK);
         CARRIAGE_REV_OUT <= (nxt_state == DSK_RETRACT);
      end
   end

   // Current cylinder follows each completed motion
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         cur_ff <= '0;
      end else if (state_ff == DSK_RETRACT && nxt_state == DSK_SETTLE) begin
         cur_ff <= '0;
      end else if (state_ff == DSK_SEEK && nxt_state == DSK_SETTLE) begin
         cur_ff <= cur_ff + diff_ff;
      end
   end

   // Drivers stay off until positioned; gating avoids writing off track
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         WRITE_DRV_EN_OUT <= 1'b0;
         READ_DATA_EN_OUT <= 1'b0;
         ERASE_EN_OUT <= 1'b0;
      end else begin
         WRITE_DRV_EN_OUT <= ctl_ff[`DSK_CB_WRITE] && positioned_ff;
         READ_DATA_EN_OUT <= ctl_ff[`DSK_CB_READ] && positioned_ff;
         ERASE_EN_OUT <= ctl_ff[`DSK_CB_ERASE] && positioned_ff;
      end
   end

   assign POSITIONED_OUT = positioned_ff;
   assign HEAD_ADDR_OUT = head_ff;
   assign STATE_OUT = state_ff;

   // ****************************************
   // Fault flag
   // ****************************************
   logic fault_ff, fault_cond, fault_clr;
   logic apb_wr, apb_setup;

   assign fault_cond = (ctl_ff[`DSK_CB_READ] && ctl_ff[`DSK_CB_WRITE])
      || ((ctl_ff[`DSK_CB_READ] || ctl_ff[`DSK_CB_WRITE] || ctl_ff[`DSK_CB_ERASE])
          && !positioned_ff);
   assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
   assign apb_setup = PSEL_IN && !PENABLE_IN;
   assign fault_clr = apb_wr && (PADDR_IN == `DSK_OFF_CTRL) && PWDATA_IN[`DSK_CTRL_FCLR];
   assign home_req = apb_wr && (PADDR_IN == `DSK_OFF_CTRL) && PWDATA_IN[`DSK_CTRL_HOME];

   // A live cause beats the clear, so the flag stays clear only once it is gone
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         fault_ff <= 1'b0;
      end else if (fault_cond) begin
         fault_ff <= 1'b1;
      end else if (fault_clr) begin
         fault_ff <= 1'b0;
      end
   end
   assign FAULT_OUT = fault_ff;

   // ****************************************
   // Interrupts and APB slave
   // ****************************************
   logic [`DSK_IRQ_W-1:0] int_sts_ff, int_mask_ff, int_evt, int_w1c;
   logic refused, positioned_q_ff;

   // Commands arriving before the drive is positioned are dropped and flagged
   assign refused = (home_req || seek_req) && (state_ff != DSK_READY);

   // Edge memory for the positioned event
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         positioned_q_ff <= 1'b0;
      end else begin
         positioned_q_ff <= positioned_ff;
      end
   end
   assign int_evt = {refused, fault_cond && !fault_ff, positioned_ff && !positioned_q_ff};
   assign int_w1c = (apb_wr && PADDR_IN == `DSK_OFF_INT_STS) ?
                    PWDATA_IN[`DSK_IRQ_W-1:0] : '0;

   // Sticky status, set wins over write-one-to-clear
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         int_sts_ff <= '0;
         int_mask_ff <= `DSK_INT_MASK_RST;
      end else begin
         int_sts_ff <= (int_sts_ff & ~int_w1c) | int_evt;
         if (apb_wr && PADDR_IN == `DSK_OFF_INT_MASK) int_mask_ff <= PWDATA_IN[`DSK_IRQ_W-1:0];
      end
   end
   assign IRQ_OUT = |(int_sts_ff & int_mask_ff);

   // Read data prepared in the setup cycle; access phase never waits
   assign PREADY_OUT = 1'b1;
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         PRDATA_OUT <= 32'h0;
         PSLVERR_OUT <= 1'b0;
      end else if (apb_setup) begin
         PSLVERR_OUT <= 1'b0;
         if (PADDR_IN == `DSK_OFF_CTRL) begin
            PRDATA_OUT <= 32'h0;
         end else if (PADDR_IN == `DSK_OFF_STATUS) begin
            PRDATA_OUT <= {26'h0, fault_ff, positioned_ff, 1'b0, state_ff};
         end else if (PADDR_IN == `DSK_OFF_POSN) begin
            PRDATA_OUT <= {ctl_ff[3:0], head_ff, 3'h0, diff_ff, 3'h0, tgt_ff, 3'h0, cur_ff};
         end else if (PADDR_IN == `DSK_OFF_INT_STS) begin
            PRDATA_OUT <= {29'h0, int_sts_ff};
         end else if (PADDR_IN == `DSK_OFF_INT_MASK) begin
            PRDATA_OUT <= {29'h0, int_mask_ff};
         end else begin
            PRDATA_OUT <= 32'h0;
            PSLVERR_OUT <= 1'b1;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!ARST_N_IN);

   logic [20:0] settle_len_ff;
   // Length of the current settle span, read by the timing check
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) settle_len_ff <= 21'h0;
      else settle_len_ff <= (state_ff == DSK_SETTLE) ? settle_len_ff + 21'h1 : 21'h0;
   end

   chk_first_seek_start: assert property (
      state_ff == DSK_IDLE && !seq_s |=> state_ff == DSK_IDLE)
      else $error("left idle without sequence signal");
   chk_load_then_reverse: assert property (
      state_ff == DSK_LOAD && loaded_s && seq_s |=> CARRIAGE_REV_OUT && !CARRIAGE_FWD_OUT)
      else $error("carriage did not reverse after heads loaded");
   chk_stop_at_zero: assert property (
      state_ff == DSK_RETRACT && det_rise && zero_s && seq_s
      |=> !CARRIAGE_REV_OUT && !CARRIAGE_FWD_OUT && cur_ff == '0)
      else $error("carriage not stopped at cylinder zero");
   chk_settle_time: assert property (
      $rose(positioned_ff) |-> settle_len_ff == 21'(SETTLE_CYCLES))
      else $error("positioned status not at settle delay");
   chk_gate_ready: assert property (
      (WRITE_DRV_EN_OUT || READ_DATA_EN_OUT || ERASE_EN_OUT) |-> $past(positioned_ff))
      else $error("driver enabled before positioned");
   chk_readback_drive: assert property (
      sel == DSK_SEL_RDCYL |=> !BUS_OE_N_OUT && BUS_DATA_OUT == $past(cur_ff))
      else $error("readback strobe did not drive bus");
   chk_weight_capture: assert property (
      sel == DSK_SEL_CYL |=> tgt_ff == $past(bus_s))
      else $error("cylinder value not captured");
   chk_write_bit: assert property (
      sel == DSK_SEL_CTL && bus_s[0] && positioned_ff ##1 positioned_ff |=> WRITE_DRV_EN_OUT)
      else $error("write bit did not enable drivers");
   chk_read_bit: assert property (
      sel == DSK_SEL_CTL && !bus_s[1] |=> ##1 !READ_DATA_EN_OUT)
      else $error("read line enabled without read bit");
   chk_seek_forward: assert property (
      state_ff == DSK_READY && seek_req && !home_req && seq_s |=> state_ff == DSK_SEEK ##0 CARRIAGE_FWD_OUT)
      else $error("seek bit did not move carriage forward");
   chk_head_clear: assert property (
      sel == DSK_SEL_CTL && bus_s[3] |=> head_ff == '0)
      else $error("head register not cleared");
   chk_erase_bit: assert property (
      sel == DSK_SEL_CTL && !bus_s[4] |=> ##1 !ERASE_EN_OUT)
      else $error("erase on without erase bit");
   chk_fault_rw: assert property (
      ctl_ff[0] && ctl_ff[1] |=> fault_ff)
      else $error("read and write together not faulted");
   chk_fault_unpos: assert property (
      (ctl_ff[0] || ctl_ff[1] || ctl_ff[4]) && !positioned_ff |=> fault_ff)
      else $error("select without positioned not faulted");
   chk_idle_bus: assert property (
      sel == DSK_SEL_NONE |=> $stable(tgt_ff) && $stable(diff_ff) && $stable(ctl_ff))
      else $error("bus captured with no strobe");

   cov_first_seek: cover property ($rose(positioned_ff) && cur_ff == '0);
   cov_seek: cover property (state_ff == DSK_SEEK ##[1:1000] state_ff == DSK_SETTLE);
   cov_fault: cover property ($rose(fault_ff));

endmodule : dsk_host_port
`default_nettype wire

/* design/dsk_pkg.sv */
package dsk_pkg;

   // ****************************************
   // Sequencer states, Gray along first seek
   // ****************************************
   typedef enum logic [2:0] {
      DSK_IDLE = 3'b000,
      DSK_SPIN = 3'b001,
      DSK_LOAD = 3'b011,
      DSK_RETRACT = 3'b010,
      DSK_SETTLE = 3'b110,
      DSK_READY = 3'b111,
      DSK_SEEK = 3'b101
   } dsk_state_t;

   // Meaning of the shared bus, picked by strobe
   typedef enum logic [2:0] {
      DSK_SEL_NONE, DSK_SEL_CYL, DSK_SEL_DIFF, DSK_SEL_RDCYL, DSK_SEL_HEAD, DSK_SEL_CTL
   } dsk_sel_t;

   // Control strobe wins if the controller overlaps strobes
   function automatic dsk_sel_t dsk_decode_sel(input logic [4:0] stb);
      if (stb[4]) return DSK_SEL_CTL;
      else if (stb[3]) return DSK_SEL_HEAD;
      else if (stb[2]) return DSK_SEL_RDCYL;
      else if (stb[1]) return DSK_SEL_DIFF;
      else if (stb[0]) return DSK_SEL_CYL;
      else return DSK_SEL_NONE;
   endfunction : dsk_decode_sel

endpackage : dsk_pkg

/* design/dsk_settle_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// Counts while run is high; done on the last cycle of the span
module dsk_settle_timer #(parameter int LIMIT = 1000000) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic run_in,
   output logic done_out
);
   logic [19:0] cnt_ff;

   assign done_out = run_in && (cnt_ff == 20'(LIMIT - 1));

   // Restarts from zero whenever run drops
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_ff <= 20'h0;
      end else if (!run_in || done_out) begin
         cnt_ff <= 20'h0;
      end else begin
         cnt_ff <= cnt_ff + 20'h1;
      end
   end
endmodule : dsk_settle_timer
`default_nettype wire

/* design/dsk_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser; first stage feeds only the second
module dsk_sync #(parameter int W = 1) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_ff;

   // Both stages clear to zero under reset
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_ff <= '0;
         q_out <= '0;
      end else begin
         meta_ff <= d_in;
         q_out <= meta_ff;
      end
   end
endmodule : dsk_sync
`default_nettype wire

/* testbench/disk_drive_host_port_first_seek_test.sv */
`timescale 1ns/10ps
`include "dsk_defs.svh"
`default_nettype none
module disk_drive_host_port_first_seek_test;
   import dsk_pkg::*;
   localparam int SETTLE = 20;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err, seq, speed, loaded;
   logic detent, cyl0, oe_n, fwd, rev, posd, wr_en, rd_en, er_en, fault, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [4:0] sel, bus_in, bus_out;
   logic [3:0] head;
   dsk_state_t state;
   int miscompares, n_compared;
   dsk_host_port #(.SETTLE_CYCLES(SETTLE)) uut (.CLK_IN(clk), .ARST_N_IN(arst_n),
      .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .SEQUENCE_IN(seq), .PACK_AT_SPEED_IN(speed), .HEADS_LOADED_IN(loaded),
      .DETENT_ENGAGED_IN(detent), .CYL_ZERO_IN(cyl0), .SELECT_IN(sel), .BUS_DATA_IN(bus_in),
      .BUS_DATA_OUT(bus_out), .BUS_OE_N_OUT(oe_n), .CARRIAGE_FWD_OUT(fwd),
      .CARRIAGE_REV_OUT(rev), .POSITIONED_OUT(posd), .WRITE_DRV_EN_OUT(wr_en),
      .READ_DATA_EN_OUT(rd_en), .ERASE_EN_OUT(er_en), .HEAD_ADDR_OUT(head),
      .FAULT_OUT(fault), .IRQ_OUT(irq), .STATE_OUT(state));
   dsk_ctl_model ctl (.clk_in(clk), .fwd_in(fwd), .rev_in(rev), .oe_n_in(oe_n),
      .dev_data_in(bus_out), .seq_out(seq), .at_speed_out(speed), .loaded_out(loaded),
      .detent_out(detent), .cyl_zero_out(cyl0), .sel_out(sel), .bus_out(bus_in));
   // ********************************
   // Shared tasks
   // ********************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // APB master; no wait count assumed, only a bounded wait for ready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 64) miscompares++;
   endtask : apb
   task automatic rdf(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdv & m, e);
   endtask : rdf
   task automatic send(input logic [4:0] s, input logic [4:0] w);
      ctl.put_word(s, w);
      ctl.put_word(5'h00, 5'h00);
   endtask : send
   task automatic wait_st(input dsk_state_t s);
      int n;
      n = 0;
      while (state !== s && n < 500) begin
         @(posedge clk);
         n++;
      end
      chk(state, s);
   endtask : wait_st
   // ********************************
   // Scenarios
   // ********************************
   task automatic t_reset;
      chk({oe_n, posd, fault, irq, fwd, rev}, 6'h20);
      rdf(`DSK_OFF_INT_MASK, 32'hffffffff, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rdv, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   // Write and seek before first seek: refused and faulted, irq masked off
   task automatic t_early;
      send(5'h10, 5'h05);
      chk({wr_en, fwd, fault, irq}, 4'h2);
      rdf(`DSK_OFF_INT_STS, 32'h7, 32'h6);
      apb(1'b1, `DSK_OFF_INT_STS, 32'h4);
      apb(1'b1, `DSK_OFF_CTRL, 32'h1);
      rdf(`DSK_OFF_INT_STS, 32'h4, 32'h4);
      send(5'h10, 5'h00);
      apb(1'b1, `DSK_OFF_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      chk(fault, 1'b0);
      apb(1'b1, `DSK_OFF_INT_STS, 32'h7);
      rdf(`DSK_OFF_INT_STS, 32'h7, 32'h0);
      $display("t_early done");
   endtask : t_early
   task automatic t_first;
      int n;
      apb(1'b1, `DSK_OFF_INT_MASK, 32'h1);
      ctl.power(1'b1);
      wait_st(DSK_LOAD);
      chk({fwd, rev}, 2'b10);
      wait_st(DSK_RETRACT);
      chk({fwd, rev}, 2'b01);
      wait_st(DSK_SETTLE);
      n = 0;
      while (posd !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(n, SETTLE);
      wait_st(DSK_READY);
      rdf(`DSK_OFF_POSN, 32'h1f, 32'h0);
      chk(irq, 1'b1);
      apb(1'b1, `DSK_OFF_INT_STS, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      $display("t_first done");
   endtask : t_first
   // Weighted fields; idle bus noise must not be captured
   task automatic t_fields;
      send(5'h08, 5'h0b);
      chk(head, 4'hb);
      send(5'h01, 5'h13);
      send(5'h02, 5'h05);
      repeat (8) @(posedge clk);
      rdf(`DSK_OFF_POSN, 32'h0f1f1f00, 32'h0b051300);
      send(5'h10, 5'h08);
      chk(head, 4'h0);
      $display("t_fields done");
   endtask : t_fields
   task automatic t_ctl;
      logic [4:0] w [3] = '{5'h01, 5'h02, 5'h10};
      foreach (w[i]) begin
         send(5'h10, w[i]);
         chk({er_en, rd_en, wr_en}, {w[i][4], w[i][1:0]});
      end
      send(5'h10, 5'h03);
      chk(fault, 1'b1);
      apb(1'b1, `DSK_OFF_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      chk(fault, 1'b1);
      send(5'h10, 5'h00);
      chk(fault, 1'b1);
      apb(1'b1, `DSK_OFF_CTRL, 32'h2);
      repeat (4) @(posedge clk);
      chk(fault, 1'b0);
      $display("t_ctl done");
   endtask : t_ctl
   // Seek by the offset, then read the cylinder back over the bus
   task automatic t_seek;
      ctl.put_word(5'h10, 5'h04);
      wait_st(DSK_SEEK);
      chk({fwd, posd}, 2'b10);
      ctl.put_word(5'h00, 5'h00);
      wait_st(DSK_READY);
      rdf(`DSK_OFF_POSN, 32'h1f, 32'h5);
      ctl.put_word(5'h04, 5'h00);
      chk({oe_n, bus_out}, 6'h05);
      ctl.put_word(5'h00, 5'h00);
      repeat (4) @(posedge clk);
      chk(oe_n, 1'b1);
      // Home recalibrate from ready retracts to cylinder zero again
      apb(1'b1, `DSK_OFF_CTRL, 32'h1);
      wait_st(DSK_RETRACT);
      chk({fwd, rev}, 2'b01);
      wait_st(DSK_READY);
      rdf(`DSK_OFF_POSN, 32'h1f, 32'h0);
      $display("t_seek done");
   endtask : t_seek
   task automatic results;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole run is under a thousand clocks; this is far past it
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end
   initial begin
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      miscompares = 0;
      n_compared = 0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_early();
      t_first();
      t_fields();
      t_ctl();
      t_seek();
      results();
   end
endmodule : disk_drive_host_port_first_seek_test
`default_nettype wire

/* testbench/dsk_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Controller and mechanism stand-in
// ********************************
module dsk_ctl_model (
   input wire logic clk_in,
   input wire logic fwd_in,
   input wire logic rev_in,
   input wire logic oe_n_in,
   input wire logic [4:0] dev_data_in,
   output logic seq_out,
   output logic at_speed_out,
   output logic loaded_out,
   output logic detent_out,
   output logic cyl_zero_out,
   output logic [4:0] sel_out,
   output logic [4:0] bus_out
);
   logic [4:0] word_ff = 5'h00;
   logic [4:0] last_ff = 5'h00;
   logic drive_ff = 1'b0;
   logic [1:0] dir_ff = 2'b00;
   logic [3:0] mv_cnt_ff = 4'h0;
   // Unpowered, carriage resting in detent
   initial begin
      seq_out = 1'b0;
      at_speed_out = 1'b0;
      loaded_out = 1'b0;
      detent_out = 1'b1;
      cyl_zero_out = 1'b0;
      sel_out = 5'h00;
   end
   // Motion counter; detent drops while moving and engages late, so motion is slow
   always @(posedge clk_in) begin
      at_speed_out <= seq_out;
      dir_ff <= {fwd_in, rev_in};
      if ({fwd_in, rev_in} != dir_ff) begin
         mv_cnt_ff <= 4'h0;
      end else if (mv_cnt_ff != 4'hf) begin
         mv_cnt_ff <= mv_cnt_ff + 4'h1;
      end
      if (fwd_in && at_speed_out && mv_cnt_ff == 4'h2) begin
         loaded_out <= 1'b1;
      end
      if (fwd_in || rev_in) begin
         detent_out <= (mv_cnt_ff >= 4'hc);
      end
      if (rev_in) begin
         cyl_zero_out <= 1'b1;
      end else if (fwd_in) begin
         cyl_zero_out <= 1'b0;
      end
      if (drive_ff) begin
         last_ff <= word_ff;
      end
   end
   // Released bus shows the inverse of the last word, never a stale copy
   assign bus_out = !oe_n_in ? dev_data_in : (drive_ff ? word_ff : ~last_ff);
   // Power sequence level toward the drive
   task automatic power(input logic on);
      @(posedge clk_in);
      seq_out <= on;
   endtask : power
   // One strobe with its word, held six clocks; readback leaves the bus free
   task automatic put_word(input logic [4:0] sel, input logic [4:0] word);
      @(posedge clk_in);
      sel_out <= sel;
      word_ff <= word;
      drive_ff <= (sel != 5'h00) && !sel[2];
      repeat (5) @(posedge clk_in);
   endtask : put_word
endmodule : dsk_ctl_model
`default_nettype wire
